// *** hdl/mds_top.sv ***
// Motion delta shaping: quantize, orient, cut off and detect finger presence.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R1: Y quantize enable divides Y by power two.
// R2: X quantize enable divides X by power two.
// R3: Both quantized: report larger axis, zero other.
// R4: Slope select bit gives linear slope 2.
// R5: Two-bit linear offset, register resets 0x02.
// R6: Motion alert only when sum exceeds threshold.
// R7: Cutoff suppresses motion below shutter limit.
// R8: On count sets frames before presence.
// R9: Off count sets frames before withdrawal.
// R10: Reflectivity compared with programmable limit.
// R11: Axis swap exchanges reported X and Y.
// R12: Vertical negate inverts reported Y only.
// R13: Horizontal negate inverts reported X only.
// R14: Quality limit used only in quality mode.
// R15: Quality compared with its own limit.
// R16: Reflectivity level stored, higher means brighter.
// R17: Status bit reads one while finger present.
// R18: Presence follows consecutive frames over limit.
module mds_top #(
  parameter int DW = 8,
  parameter int SW = 16
) (
  input  wire logic          clock_in,
  input  wire logic          rst_n_in,
  input  wire logic [7:0]    reg_addr_in,
  input  wire logic          reg_wr_in,
  input  wire logic [7:0]    reg_wdata_in,
  input  wire logic          frame_valid_in,
  input  wire logic [DW-1:0] delta_x_in,
  input  wire logic [DW-1:0] delta_y_in,
  input  wire logic [SW-1:0] shutter_in,
  input  wire logic [7:0]    reflect_in,
  input  wire logic [7:0]    quality_in,
  input  wire logic          motion_cutoff_enable_in,
  input  wire logic          quality_detect_enable_in,
  output logic [7:0]         reg_rdata_out,
  output logic               report_valid_out,
  output logic [DW:0]        report_x_out,
  output logic [DW:0]        report_y_out,
  output logic               motion_alert_out,
  output logic               finger_present_out
);
  import mds_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Magnitude of a signed value; one bit wider input avoids overflow of -128.
  function automatic logic [DW:0] mag_of(input logic [DW:0] v);
    mag_of = v[DW] ? (~v + 1'b1) : v;
  endfunction

  // Quantize one axis: small values sit in the linear region, large ones are
  // shifted down. Sign is kept separately so that negative steps round to zero.
  function automatic logic [DW:0] quantize(input logic [DW:0] v,
                                           input logic en,
                                           input logic [2:0] div,
                                           input logic slope,
                                           input logic [1:0] off);
    logic [DW:0] m;
    logic [DW:0] r;
    m = mag_of(v);
    if (m <= {{(DW-1){1'b0}}, off}) begin
      r = slope ? (m << 1) : m;
    end else begin
      r = m >> div;
    end
    if (!en) begin
      quantize = v;
    end else begin
      quantize = v[DW] ? (~r + 1'b1) : r;
    end
  endfunction

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] quant_setup;
  logic [7:0] quant_gradient_setup;
  logic [7:0] motion_alert_threshold;
  logic [7:0] finger_detect_setup;
  logic [7:0] finger_reflect_limit;
  logic [7:0] axis_orientation;
  logic [7:0] finger_quality_limit;
  logic [7:0] finger_reflect_level;
  logic [7:0] next_quant_setup;
  logic [7:0] next_gradient;
  logic [7:0] next_alert;
  logic [7:0] next_finger_setup;
  logic [7:0] next_reflect_limit;
  logic [7:0] next_orientation;
  logic [7:0] next_quality_limit;
  logic [7:0] next_reflect_level;

  // Host writes land here; a frame's measured level overrides a write in the
  // same cycle so that a measurement is never lost to a simultaneous write.
  always_comb begin
    next_quant_setup   = quant_setup;
    next_gradient      = quant_gradient_setup;
    next_alert         = motion_alert_threshold;
    next_finger_setup  = finger_detect_setup;
    next_reflect_limit = finger_reflect_limit;
    next_orientation   = axis_orientation;
    next_quality_limit = finger_quality_limit;
    next_reflect_level = finger_reflect_level;
    if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_QUANT_SETUP:   next_quant_setup   = reg_wdata_in;
        ADDR_GRADIENT:      next_gradient      = {5'h00, reg_wdata_in[2:0]}; // see R5
        ADDR_MOTION_ALERT:  next_alert         = {5'h00, reg_wdata_in[2:0]};
        ADDR_FINGER_SETUP:  next_finger_setup  = reg_wdata_in;
        ADDR_REFLECT_LIMIT: next_reflect_limit = reg_wdata_in;
        ADDR_ORIENTATION:   next_orientation   = {reg_wdata_in[7:5], 5'h00};
        ADDR_QUALITY_LIMIT: next_quality_limit = reg_wdata_in;
        ADDR_REFLECT_LEVEL: next_reflect_level = reg_wdata_in;
        default:            next_quant_setup   = quant_setup;
      endcase
    end
    if (frame_valid_in) begin
      next_reflect_level = reflect_in; // see R16
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quant_setup            <= RST_QUANT_SETUP;
      quant_gradient_setup   <= RST_GRADIENT;
      motion_alert_threshold <= RST_MOTION_ALERT;
      finger_detect_setup    <= RST_FINGER_SETUP;
      finger_reflect_limit   <= RST_REFLECT_LIMIT;
      axis_orientation       <= RST_ORIENTATION;
      finger_quality_limit   <= RST_QUALITY_LIMIT;
      finger_reflect_level   <= RST_REFLECT_LEVEL;
    end else begin
      quant_setup            <= next_quant_setup;
      quant_gradient_setup   <= next_gradient;
      motion_alert_threshold <= next_alert;
      finger_detect_setup    <= next_finger_setup;
      finger_reflect_limit   <= next_reflect_limit;
      axis_orientation       <= next_orientation;
      finger_quality_limit   <= next_quality_limit;
      finger_reflect_level   <= next_reflect_level;
    end
  end

  // ----------------------------------------
  // Delta datapath
  // ----------------------------------------
  logic          y_quant_enable;
  logic          x_quant_enable;
  logic [2:0]    y_quant_divisor;
  logic [2:0]    x_quant_divisor;
  logic          linear_slope_select;
  logic [1:0]    linear_region_offset;
  logic [SW-1:0] cutoff_limit;
  logic          cut_active;
  logic [DW:0]   raw_x;
  logic [DW:0]   raw_y;
  logic [DW:0]   ori_x;
  logic [DW:0]   ori_y;
  logic [DW:0]   q_x;
  logic [DW:0]   q_y;
  logic [DW+1:0] mag_sum;
  logic          next_valid;
  logic [DW:0]   next_x;
  logic [DW:0]   next_y;
  logic          next_motion;

  assign y_quant_enable       = quant_setup[Y_QUANT_ENABLE_BIT];
  assign x_quant_enable       = quant_setup[X_QUANT_ENABLE_BIT];
  assign y_quant_divisor      = quant_setup[Y_DIVISOR_LSB +: 3];
  assign x_quant_divisor      = quant_setup[X_DIVISOR_LSB +: 3];
  assign linear_slope_select  = quant_gradient_setup[SLOPE_SELECT_BIT];
  assign linear_region_offset = quant_gradient_setup[OFFSET_LSB +: 2];
  assign cutoff_limit = SW'(finger_detect_setup[CUTOFF_LSB +: 4]) << CUTOFF_UNIT_SHIFT;
  assign cut_active   = motion_cutoff_enable_in && (shutter_in < cutoff_limit); // see R7
  assign raw_x        = {delta_x_in[DW-1], delta_x_in};
  assign raw_y        = {delta_y_in[DW-1], delta_y_in};

  // Orientation is applied to the raw counts before quantizing, so the
  // quantizer settings always follow the reported axis, not the optical one.
  always_comb begin
    ori_x = axis_orientation[AXIS_SWAP_BIT] ? raw_y : raw_x; // see R11
    ori_y = axis_orientation[AXIS_SWAP_BIT] ? raw_x : raw_y; // see R11
    if (axis_orientation[HORIZONTAL_NEG_BIT]) begin
      ori_x = ~ori_x + 1'b1; // see R13
    end
    if (axis_orientation[VERTICAL_NEGATE_BIT]) begin
      ori_y = ~ori_y + 1'b1; // see R12
    end
    q_x = quantize(ori_x, x_quant_enable, x_quant_divisor,
                   linear_slope_select, linear_region_offset); // see R2, R4, R5
    q_y = quantize(ori_y, y_quant_enable, y_quant_divisor,
                   linear_slope_select, linear_region_offset); // see R1, R4, R5
    if (x_quant_enable && y_quant_enable) begin
      // Ties keep X so that exactly one axis survives.
      if (mag_of(q_x) >= mag_of(q_y)) begin
        q_y = '0; // see R3
      end else begin
        q_x = '0; // see R3
      end
    end
    if (cut_active) begin
      q_x = '0; // see R7
      q_y = '0;
    end
    mag_sum     = {1'b0, mag_of(q_x)} + {1'b0, mag_of(q_y)};
    next_valid  = frame_valid_in;
    next_x      = frame_valid_in ? q_x : report_x_out;
    next_y      = frame_valid_in ? q_y : report_y_out;
    next_motion = frame_valid_in ? (mag_sum > (DW+2)'(motion_alert_threshold[2:0]))
                                 : motion_alert_out; // see R6
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      report_valid_out <= 1'b0;
      report_x_out     <= '0;
      report_y_out     <= '0;
      motion_alert_out <= 1'b0;
    end else begin
      report_valid_out <= next_valid;
      report_x_out     <= next_x;
      report_y_out     <= next_y;
      motion_alert_out <= next_motion;
    end
  end

  // ----------------------------------------
  // Finger presence with hysteresis
  // ----------------------------------------
  mds_finger_t finger_state;
  mds_finger_t next_finger_state;
  logic [1:0]  hyst_cnt;
  logic [1:0]  next_hyst_cnt;
  logic        finger_hit;
  logic [1:0]  presence_on_count;
  logic [1:0]  presence_off_count;

  assign presence_on_count  = finger_detect_setup[ON_COUNT_LSB +: 2];
  assign presence_off_count = finger_detect_setup[OFF_COUNT_LSB +: 2];
  // Quality mode serves dark surfaces where reflectivity alone is unreliable.
  assign finger_hit = quality_detect_enable_in ? (quality_in > finger_quality_limit) // see R14, R15
                                               : (reflect_in > finger_reflect_limit); // see R10

  // A count of N needs N+1 consecutive agreeing frames; any disagreeing
  // frame restarts the count, which filters single noisy frames. A count
  // lowered mid-run takes effect at the next agreeing frame instead of wrapping.
  always_comb begin
    next_finger_state = finger_state;
    next_hyst_cnt     = hyst_cnt;
    if (frame_valid_in) begin
      case (finger_state)
        FINGER_ABSENT: begin
          if (!finger_hit) begin
            next_hyst_cnt = 2'h0;
          end else if (hyst_cnt >= presence_on_count) begin
            next_finger_state = FINGER_PRESENT; // see R8, R18
            next_hyst_cnt     = 2'h0;
          end else begin
            next_hyst_cnt = hyst_cnt + 2'h1;
          end
        end
        FINGER_PRESENT: begin
          if (finger_hit) begin
            next_hyst_cnt = 2'h0;
          end else if (hyst_cnt >= presence_off_count) begin
            next_finger_state = FINGER_ABSENT; // see R9, R18
            next_hyst_cnt     = 2'h0;
          end else begin
            next_hyst_cnt = hyst_cnt + 2'h1;
          end
        end
        default: begin
          next_finger_state = FINGER_ABSENT;
          next_hyst_cnt     = 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      finger_state       <= FINGER_ABSENT;
      hyst_cnt           <= 2'h0;
      finger_present_out <= 1'b0;
    end else begin
      finger_state       <= next_finger_state;
      hyst_cnt           <= next_hyst_cnt;
      finger_present_out <= (next_finger_state == FINGER_PRESENT); // see R17
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  logic [7:0] next_rdata;

  // Unmapped offsets read as zero.
  always_comb begin
    case (reg_addr_in)
      ADDR_QUANT_SETUP:   next_rdata = quant_setup;
      ADDR_GRADIENT:      next_rdata = quant_gradient_setup;
      ADDR_MOTION_ALERT:  next_rdata = motion_alert_threshold;
      ADDR_FINGER_SETUP:  next_rdata = finger_detect_setup;
      ADDR_REFLECT_LIMIT: next_rdata = finger_reflect_limit;
      ADDR_ORIENTATION:   next_rdata = axis_orientation;
      ADDR_QUALITY_LIMIT: next_rdata = finger_quality_limit;
      ADDR_REFLECT_LEVEL: next_rdata = finger_reflect_level;
      ADDR_FINGER_STATUS: next_rdata = {7'h00, finger_present_out}; // see R17
      default:            next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_cutoff_zeroes: assert property (frame_valid_in && cut_active |=> // see R7
      report_x_out == '0 && report_y_out == '0 && !motion_alert_out)
    else $error("cutoff frame reported motion");
  a_alert_sum: assert property (report_valid_out && motion_alert_out |-> // see R6
      ({1'b0, mag_of(report_x_out)} + {1'b0, mag_of(report_y_out)})
        > (DW+2)'($past(motion_alert_threshold[2:0])))
    else $error("alert without sum above threshold");
  a_single_axis: assert property (frame_valid_in && x_quant_enable && y_quant_enable // see R3
      |=> report_x_out == '0 || report_y_out == '0)
    else $error("both axes reported while quantized");
  a_swap_plain: assert property (frame_valid_in && !cut_active // see R11
      && axis_orientation == 8'h80 && !x_quant_enable |=> report_x_out == $past(raw_y))
    else $error("swap did not move Y into X");
  a_y_negate: assert property (frame_valid_in && !cut_active // see R12
      && axis_orientation == 8'h40 && !y_quant_enable
      |=> report_y_out == (DW+1)'(~$past(raw_y) + 1'b1))
    else $error("Y not negated");
  a_x_negate: assert property (frame_valid_in && !cut_active // see R13
      && axis_orientation == 8'h20 && !x_quant_enable && !y_quant_enable
      |=> report_x_out == (DW+1)'(~$past(raw_x) + 1'b1))
    else $error("X not negated");
  a_y_divide: assert property (frame_valid_in && !cut_active && y_quant_enable // see R1
      && !x_quant_enable && axis_orientation == 8'h00
      && mag_of(raw_y) > (DW+1)'(linear_region_offset)
      |=> mag_of(report_y_out) == (mag_of($past(raw_y)) >> $past(y_quant_divisor)))
    else $error("Y divide wrong");
  a_on_hyst: assert property ($rose(finger_present_out) |-> // see R8
      $past(frame_valid_in) && $past(hyst_cnt) >= $past(presence_on_count))
    else $error("presence set before on count reached");
  a_off_hyst: assert property ($fell(finger_present_out) |-> // see R9
      $past(frame_valid_in) && $past(hyst_cnt) >= $past(presence_off_count))
    else $error("presence cleared before off count reached");
  a_status_read: assert property (reg_addr_in == ADDR_FINGER_STATUS // see R17
      |=> reg_rdata_out == {7'h00, $past(finger_present_out)})
    else $error("status read wrong");

  c_finger_on:  cover property ($rose(finger_present_out));
  c_finger_off: cover property ($fell(finger_present_out));
  c_alert:      cover property (report_valid_out && motion_alert_out);
  c_cutoff:     cover property (frame_valid_in && cut_active);
endmodule
`default_nettype wire

// *** hdl/mds_pkg.sv ***
// Constants for the motion delta shaping block.
package mds_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_QUANT_SETUP    = 8'h72;
  localparam logic [7:0] ADDR_GRADIENT       = 8'h73;
  localparam logic [7:0] ADDR_MOTION_ALERT   = 8'h74;
  localparam logic [7:0] ADDR_FINGER_SETUP   = 8'h75;
  localparam logic [7:0] ADDR_REFLECT_LIMIT  = 8'h76;
  localparam logic [7:0] ADDR_ORIENTATION    = 8'h77;
  localparam logic [7:0] ADDR_QUALITY_LIMIT  = 8'h78;
  localparam logic [7:0] ADDR_REFLECT_LEVEL  = 8'h79;
  localparam logic [7:0] ADDR_FINGER_STATUS  = 8'h7a;
  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [7:0] RST_QUANT_SETUP     = 8'h99;
  localparam logic [7:0] RST_GRADIENT        = 8'h02;
  localparam logic [7:0] RST_MOTION_ALERT    = 8'h00;
  localparam logic [7:0] RST_FINGER_SETUP    = 8'hfa;
  localparam logic [7:0] RST_REFLECT_LIMIT   = 8'h1c;
  localparam logic [7:0] RST_ORIENTATION     = 8'h00;
  localparam logic [7:0] RST_QUALITY_LIMIT   = 8'h40;
  localparam logic [7:0] RST_REFLECT_LEVEL   = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int Y_QUANT_ENABLE_BIT  = 7;
  localparam int Y_DIVISOR_LSB       = 4;
  localparam int X_QUANT_ENABLE_BIT  = 3;
  localparam int X_DIVISOR_LSB       = 0;
  localparam int SLOPE_SELECT_BIT    = 2;
  localparam int OFFSET_LSB          = 0;
  localparam int ALERT_LSB           = 0;
  localparam int CUTOFF_LSB          = 4;
  localparam int ON_COUNT_LSB        = 2;
  localparam int OFF_COUNT_LSB       = 0;
  localparam int AXIS_SWAP_BIT       = 7;
  localparam int VERTICAL_NEGATE_BIT = 6;
  localparam int HORIZONTAL_NEG_BIT  = 5;
  localparam int PRESENT_FLAG_BIT    = 0;
  // Cutoff field units, in shutter counts (shift of 8 is a factor of 256).
  localparam int CUTOFF_UNIT_SHIFT   = 8;
  // Finger presence states, one-hot.
  typedef enum logic [1:0] {
    FINGER_ABSENT  = 2'b01,
    FINGER_PRESENT = 2'b10
  } mds_finger_t;
endpackage

// *** testbench/mds_host.sv ***
// Host controller model that reaches the shaping block's registers.
`timescale 1ns/100ps
`default_nettype none
module mds_host (
  input  wire logic       clock_in,
  input  wire logic [7:0] rdata_in,
  output logic [7:0]      addr_out,
  output logic            wr_out,
  output logic [7:0]      wdata_out
);
  // ----------------------------------------
  // Register cycles
  // ----------------------------------------
  // Signals idle low so nothing is written before the first real cycle.
  initial begin
    addr_out  = 8'h00;
    wr_out    = 1'b0;
    wdata_out = 8'h00;
  end

  // One-cycle write strobe, changed only on the falling edge.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    addr_out  = a;
    wdata_out = d;
    wr_out    = 1'b1;
    @(negedge clock_in);
    wr_out    = 1'b0;
    wdata_out = ~d; // The data lines no longer carry the written byte.
  endtask

  // Read data is registered, so it is taken one cycle after the address.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_in);
    addr_out = a;
    @(negedge clock_in);
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// *** testbench/mds_top_tb.sv ***
// Self-checking bench for the motion delta shaping block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module mds_top_tb;
  import mds_pkg::*;
  logic clock_in = 1'b0, rst_n_in = 1'b0, reg_wr_in, frame_valid_in = 1'b0;
  logic [7:0] reg_addr_in, reg_wdata_in, delta_x_in = 8'h00, delta_y_in = 8'h00;
  logic [15:0] shutter_in = 16'h0000;
  logic [7:0] reflect_in = 8'h00, quality_in = 8'h00, reg_rdata_out, rd;
  logic motion_cutoff_enable_in = 1'b0, quality_detect_enable_in = 1'b0;
  logic report_valid_out, motion_alert_out, finger_present_out, pres;
  logic [8:0] report_x_out, report_y_out;
  logic [7:0] mreg [0:7];
  int fails = 0, cmp_count = 0, cnt, i, k;

  always #50 clock_in = ~clock_in;

  mds_host host (.clock_in(clock_in), .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
                 .wr_out(reg_wr_in), .wdata_out(reg_wdata_in));

  mds_top uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .frame_valid_in(frame_valid_in),
    .delta_x_in(delta_x_in), .delta_y_in(delta_y_in), .shutter_in(shutter_in),
    .reflect_in(reflect_in), .quality_in(quality_in),
    .motion_cutoff_enable_in(motion_cutoff_enable_in),
    .quality_detect_enable_in(quality_detect_enable_in), .reg_rdata_out(reg_rdata_out),
    .report_valid_out(report_valid_out), .report_x_out(report_x_out),
    .report_y_out(report_y_out), .motion_alert_out(motion_alert_out),
    .finger_present_out(finger_present_out));

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic int mag(input int v);
    return (v < 0) ? -v : v;
  endfunction

  // Small values follow the linear region, larger ones the power-of-two divide.
  function automatic int quant(input int v, input bit en, input int dv);
    int r;
    r = mag(v);
    if (!en) return v;
    if (r <= int'(mreg[1][1:0])) r = r * (mreg[1][2] ? 2 : 1);
    else r = r >> dv;
    return (v < 0) ? -r : r;
  endfunction

  // Status reads back the presence flag; unmapped places read zero.
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a >= 8'h72 && a <= 8'h79) return mreg[a - 8'h72];
    if (a == 8'h7a) return {7'h00, pres};
    return 8'h00;
  endfunction

  // Reserved bits are kept at zero by the model as well.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h73 || a == 8'h74) mreg[a - 8'h72] = d & 8'h07;
    else if (a == 8'h77) mreg[5] = d & 8'he0;
    else if (a >= 8'h72 && a <= 8'h79) mreg[a - 8'h72] = d;
    host.write_reg(a, d);
  endtask

  task automatic chk_rd(input logic [7:0] a);
    host.read_reg(a, rd);
    `CHK("register read", exp_rd(a), rd)
  endtask

  // Drives one frame and compares every result with the model.
  task automatic frame(input int dx, input int dy, input int sh, input int rf, input int qu,
                       input bit ce, input bit qe);
    int x, y, t, n;
    bit hit, al;
    @(negedge clock_in);
    frame_valid_in = 1'b1;
    delta_x_in = dx[7:0];
    delta_y_in = dy[7:0];
    shutter_in = sh[15:0];
    reflect_in = rf[7:0];
    quality_in = qu[7:0];
    motion_cutoff_enable_in = ce;
    quality_detect_enable_in = qe;
    x = dx;
    y = dy;
    if (mreg[5][7]) begin
      t = x;
      x = y;
      y = t;
    end
    if (mreg[5][6]) y = -y;
    if (mreg[5][5]) x = -x;
    x = quant(x, mreg[0][3], int'(mreg[0][2:0]));
    y = quant(y, mreg[0][7], int'(mreg[0][6:4]));
    if (mreg[0][3] && mreg[0][7]) begin
      if (mag(y) > mag(x)) x = 0;
      else y = 0;
    end
    if (ce && sh < int'(mreg[3][7:4]) * 256) begin
      x = 0;
      y = 0;
    end
    al = (mag(x) + mag(y)) > int'(mreg[2][2:0]);
    mreg[7] = rf[7:0];
    hit = qe ? (qu > int'(mreg[6])) : (rf > int'(mreg[4]));
    n = pres ? int'(mreg[3][1:0]) : int'(mreg[3][3:2]);
    if (hit != pres) begin
      cnt++;
      if (cnt > n) begin
        pres = hit;
        cnt = 0;
      end
    end else cnt = 0;
    @(negedge clock_in);
    frame_valid_in = 1'b0;
    delta_x_in = ~dx[7:0];
    `CHK("report valid", 1'b1, report_valid_out)
    `CHK("report x", x[8:0], report_x_out)
    `CHK("report y", y[8:0], report_y_out)
    `CHK("motion alert", al, motion_alert_out)
    `CHK("finger present", pres, finger_present_out)
    @(negedge clock_in);
    `CHK("report valid drop", 1'b0, report_valid_out)
  endtask

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic finish_test();
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Cuts a hang short well inside the cycle budget.
  initial begin
    repeat (90000) @(posedge clock_in);
    fails++;
    finish_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    mreg = '{RST_QUANT_SETUP, RST_GRADIENT, RST_MOTION_ALERT, RST_FINGER_SETUP,
             RST_REFLECT_LIMIT, RST_ORIENTATION, RST_QUALITY_LIMIT, RST_REFLECT_LEVEL};
    pres = 1'b0;
    cnt = 0;
    void'($urandom(32'h166ca50b));
    repeat (6) @(negedge clock_in);
    rst_n_in = 1'b1;
    // Reset values, then reserved bits, the read-only status and a hole.
    for (k = 8'h72; k <= 8'h7b; k++) chk_rd(k[7:0]);
    wr(8'h73, 8'hff);
    wr(8'h74, 8'hff);
    wr(8'h77, 8'hff);
    wr(8'h7a, 8'hff);
    for (k = 8'h72; k <= 8'h7a; k++) chk_rd(k[7:0]);
    wr(8'h73, RST_GRADIENT);
    wr(8'h74, RST_MOTION_ALERT);
    wr(8'h77, RST_ORIENTATION);
    // Reset configuration: both quantizers on, larger axis kept.
    frame(3, -2, 0, 0, 0, 1'b0, 1'b0);
    // A frame and a level write in one cycle: the frame's value is kept.
    fork
      wr(8'h79, 8'h55);
      frame(1, 1, 0, 8'h33, 0, 1'b0, 1'b0);
    join
    mreg[7] = 8'h33;
    chk_rd(8'h79);
    // Most negative input negated on both axes stays exact.
    wr(8'h72, 8'h00);
    wr(8'h77, 8'h60);
    frame(-128, -128, 0, 0, 0, 1'b0, 1'b0);
    // Random configurations with runs of covered and uncovered frames.
    for (i = 0; i < 240; i++) begin
      if (i % 12 == 0) begin
        for (k = 8'h72; k <= 8'h78; k++) wr(k[7:0], 8'($urandom));
        chk_rd(8'h79);
        chk_rd(8'h7a);
      end
      frame($urandom % 2 ? int'($signed(8'($urandom))) : int'($urandom % 16) - 8,
            $urandom % 2 ? int'($signed(8'($urandom))) : int'($urandom % 16) - 8,
            int'($urandom % 65536),
            $urandom % 8 == 0 ? int'($urandom % 256) : ((i / 7) % 2) * 255,
            $urandom % 8 == 0 ? int'($urandom % 256) : ((i / 9) % 2) * 255,
            1'($urandom), (i / 60) % 2 == 1);
    end
    finish_test();
  end
endmodule
`default_nettype wire
